// [design/oag_addr_gen.v]
// operand effective-address generator for the 8-bit core
//
// Operation
// [RULE_01] register mode: operand is the named register contents
// [RULE_02] window pointer picks 8-byte slice, field picks register
// [RULE_03] indirect: 8-bit points file, pair points memory; code sends the pair to the file for ops other than LDC, LDE
// [RULE_04] indirect never reaches set-1 upper area; code sets alt_set_d only for the 8-bit pointer
// [RULE_05] indexed never reaches set-1 upper area
// [RULE_06] short indexed offset sign-extended, external only
// [RULE_07] file indexed: instruction base plus register offset
// [RULE_08] memory indexed: register pair base plus offset
// [RULE_09] file indexing only for plain register load
// [RULE_10] absolute address loads pc for jump, call
// [RULE_11] memory loads take absolute address either way
// [RULE_12] vector: low-page pair gives next address
// [RULE_13] vector indirect mode only for call
// [RULE_14] relative: signed byte added to pc
// [RULE_15] pc already points past current instruction
// [RULE_16] relative only for the six branch ops
// [RULE_17] literal operand is a byte or word
// [RULE_18] pointer high five bits join field low three
// [RULE_19] 8-bit address with 1100 nibble is working
// [RULE_20] file index sum wraps at 256
`include "oag_defines.vh"
`default_nettype none

module oag_addr_gen #(
    parameter ADDR_W = 16,
    parameter DATA_W = 8
) (
    // clock and reset
    input  wire                     core_clk,
    input  wire                     srst,
    // request from decode
    input  wire                     req_valid,
    input  wire [`OAG_MODE_W-1:0]   req_mode,
    input  wire [`OAG_OP_W-1:0]     req_op,
    input  wire [DATA_W-1:0]        reg_field,
    input  wire                     reg_short,
    input  wire                     reg_wide,
    input  wire [ADDR_W-1:0]        imm_val,
    input  wire                     imm_wide,
    input  wire                     idx_short,
    // core state
    input  wire [DATA_W-1:0]        first_window_pointer,
    input  wire [DATA_W-1:0]        second_window_pointer,
    input  wire [DATA_W-1:0]        reg_val,
    input  wire [ADDR_W-1:0]        pair_val,
    input  wire [ADDR_W-1:0]        pc_next,
    // vector fetch return
    input  wire                     vec_valid,
    input  wire [ADDR_W-1:0]        vec_data,
    // answer
    output reg                      ready_q,
    output reg                      res_valid_q,
    output reg  [`OAG_SP_W-1:0]     res_space_q,
    output reg  [ADDR_W-1:0]        res_addr_q,
    output reg  [ADDR_W-1:0]        res_operand_q,
    output reg  [DATA_W-1:0]        res_reg_q,
    output reg                      res_alt_set_q,
    output reg                      res_error_q,
    output reg                      pc_load_q,
    // vector fetch request
    output reg                      vec_rd_q,
    output reg  [ADDR_W-1:0]        vec_addr_q
);

    localparam HI_W = ADDR_W - DATA_W;

    // window pointer keeps its top five bits, field gives three
    function [DATA_W-1:0] wr_addr;
        input [3:0]        f;
        input [DATA_W-1:0] p0;
        input [DATA_W-1:0] p1;
        begin
            if (f[`OAG_PTR_SEL_BIT]) begin
                wr_addr = {p1[DATA_W-1:3], f[2:0]}; // [RULE_18] [RULE_02]
            end else begin
                wr_addr = {p0[DATA_W-1:3], f[2:0]}; // [RULE_18] [RULE_02]
            end
        end
    endfunction

    reg [`OAG_ST_W-1:0]  state_q;
    reg [`OAG_ST_W-1:0]  state_d;

    wire [DATA_W-1:0] named_reg;
    wire [ADDR_W-1:0] disp_sext;
    wire [ADDR_W-1:0] lit_val;
    wire [DATA_W-1:0] rf_idx_sum;
    wire [ADDR_W-1:0] mem_idx_sum;
    wire [ADDR_W-1:0] rel_sum;
    wire              is_branch;
    wire              is_memload;
    wire              take;

    assign take = req_valid & ready_q;

    assign named_reg = (reg_short || reg_field[DATA_W-1:4] == `OAG_WR_NIBBLE) ?
                       wr_addr(reg_field[3:0], first_window_pointer,
                               second_window_pointer) : // [RULE_19]
                       reg_field;

    assign disp_sext = {{HI_W{imm_val[DATA_W-1]}}, imm_val[DATA_W-1:0]};

    assign lit_val = imm_wide ? imm_val :
                     {{HI_W{1'b0}}, imm_val[DATA_W-1:0]}; // [RULE_17]

    // carry out of the byte is dropped on purpose
    assign rf_idx_sum = imm_val[DATA_W-1:0] + reg_val; // [RULE_07] [RULE_20]

    assign mem_idx_sum = pair_val + (idx_short ? disp_sext : imm_val); // [RULE_08] [RULE_06]

    // pc_next is the address after this instruction
    assign rel_sum = pc_next + disp_sext; // [RULE_14] [RULE_15]

    assign is_branch = (req_op == `OAG_OP_BTJF) || (req_op == `OAG_OP_BTJT) ||
                       (req_op == `OAG_OP_DECREMENT_JUMP_NONZERO_OP) || (req_op == `OAG_OP_COMPARE_INC_JUMP_EQUAL_OP) ||
                       (req_op == `OAG_OP_COMPARE_INC_JUMP_UNEQUAL_OP) || (req_op == `OAG_OP_JR); // [RULE_16]

    assign is_memload = (req_op == `OAG_OP_LDC) || (req_op == `OAG_OP_LDE);

    reg [`OAG_SP_W-1:0] space_d;
    reg [ADDR_W-1:0]    addr_d;
    reg [ADDR_W-1:0]    operand_d;
    reg                 alt_set_d;
    reg                 error_d;
    reg                 pc_load_d;
    reg                 vec_start_d;

    always @* begin
        space_d     = `OAG_SP_NONE;
        addr_d      = {ADDR_W{1'b0}};
        operand_d   = {ADDR_W{1'b0}};
        alt_set_d   = 1'b0;
        error_d     = 1'b0;
        pc_load_d   = 1'b0;
        vec_start_d = 1'b0;
        case (req_mode)
            `OAG_MODE_REG: begin
                space_d   = `OAG_SP_RF;
                addr_d    = {{HI_W{1'b0}}, named_reg};
                operand_d = reg_wide ? pair_val :
                            {{HI_W{1'b0}}, reg_val}; // [RULE_01]
            end
            `OAG_MODE_IND: begin
                if (reg_wide) begin
                    addr_d = pair_val; // [RULE_03]
                    if (req_op == `OAG_OP_LDC) begin
                        space_d = `OAG_SP_PROG;
                    end else if (req_op == `OAG_OP_LDE) begin
                        space_d = `OAG_SP_EXT;
                    end else begin
                        space_d = `OAG_SP_RF;
                    end
                end else begin
                    space_d = `OAG_SP_RF;
                    addr_d  = {{HI_W{1'b0}}, reg_val}; // [RULE_03]
                    // upper area is steered away from set 1
                    alt_set_d = (reg_val[DATA_W-1:DATA_W-2] == `OAG_SET1_HI); // [RULE_04]
                end
            end
            `OAG_MODE_IDX: begin
                if (req_op == `OAG_OP_LD) begin
                    space_d   = `OAG_SP_RF;
                    addr_d    = {{HI_W{1'b0}}, rf_idx_sum};
                    alt_set_d = (rf_idx_sum[DATA_W-1:DATA_W-2] == `OAG_SET1_HI); // [RULE_05]
                    error_d   = idx_short;
                end else if (req_op == `OAG_OP_LDC) begin
                    space_d = `OAG_SP_PROG;
                    addr_d  = mem_idx_sum;
                    error_d = idx_short; // [RULE_06]
                end else if (req_op == `OAG_OP_LDE) begin
                    space_d = `OAG_SP_EXT;
                    addr_d  = mem_idx_sum; // [RULE_08]
                end else begin
                    error_d = 1'b1; // [RULE_09]
                end
            end
            `OAG_MODE_ABS: begin
                addr_d = imm_val;
                if (req_op == `OAG_OP_JP || req_op == `OAG_OP_CALL) begin
                    space_d   = `OAG_SP_PC;
                    pc_load_d = 1'b1; // [RULE_10]
                end else if (req_op == `OAG_OP_LDC) begin
                    space_d = `OAG_SP_PROG; // [RULE_11]
                end else if (req_op == `OAG_OP_LDE) begin
                    space_d = `OAG_SP_EXT; // [RULE_11]
                end else begin
                    error_d = 1'b1;
                end
            end
            `OAG_MODE_VEC: begin
                if (req_op == `OAG_OP_CALL) begin
                    vec_start_d = 1'b1; // [RULE_13]
                end else begin
                    error_d = 1'b1; // [RULE_13]
                end
            end
            `OAG_MODE_REL: begin
                if (is_branch) begin
                    space_d   = `OAG_SP_PC;
                    addr_d    = rel_sum;
                    pc_load_d = 1'b1; // [RULE_14]
                end else begin
                    error_d = 1'b1; // [RULE_16]
                end
            end
            `OAG_MODE_LIT: begin
                space_d   = `OAG_SP_LIT;
                operand_d = lit_val; // [RULE_17]
            end
            default: begin
                error_d = 1'b1;
            end
        endcase
    end

    // vector fetch holds the block busy until the pair returns
    always @* begin
        case (state_q)
            `OAG_ST_IDLE: begin
                if (take && vec_start_d) begin
                    state_d = `OAG_ST_VEC;
                end else begin
                    state_d = `OAG_ST_IDLE;
                end
            end
            `OAG_ST_VEC: begin
                if (vec_valid) begin
                    state_d = `OAG_ST_IDLE;
                end else begin
                    state_d = `OAG_ST_VEC;
                end
            end
            default: begin
                state_d = `OAG_ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            state_q       <= `OAG_ST_IDLE;
            ready_q       <= 1'b0;
            res_valid_q   <= 1'b0;
            res_space_q   <= `OAG_SP_NONE;
            res_addr_q    <= {ADDR_W{1'b0}};
            res_operand_q <= {ADDR_W{1'b0}};
            res_reg_q     <= {DATA_W{1'b0}};
            res_alt_set_q <= 1'b0;
            res_error_q   <= 1'b0;
            pc_load_q     <= 1'b0;
            vec_rd_q      <= 1'b0;
            vec_addr_q    <= {ADDR_W{1'b0}};
        end else begin
            state_q     <= state_d;
            ready_q     <= (state_d == `OAG_ST_IDLE);
            res_valid_q <= 1'b0;
            pc_load_q   <= 1'b0;
            vec_rd_q    <= 1'b0;
            if (state_q == `OAG_ST_VEC) begin
                if (vec_valid) begin
                    res_valid_q   <= 1'b1;
                    res_space_q   <= `OAG_SP_PC;
                    res_addr_q    <= vec_data; // [RULE_12]
                    res_operand_q <= {ADDR_W{1'b0}};
                    res_alt_set_q <= 1'b0;
                    res_error_q   <= 1'b0;
                    pc_load_q     <= 1'b1; // [RULE_12]
                end
            end else if (take) begin
                res_reg_q <= named_reg;
                if (vec_start_d) begin
                    vec_rd_q   <= 1'b1;
                    // only the low page is reachable: upper byte forced to zero
                    vec_addr_q <= {`OAG_VEC_PAGE, reg_field}; // [RULE_12]
                end else begin
                    res_valid_q   <= 1'b1;
                    res_space_q   <= space_d;
                    res_addr_q    <= addr_d;
                    res_operand_q <= operand_d;
                    res_alt_set_q <= alt_set_d;
                    res_error_q   <= error_d;
                    pc_load_q     <= pc_load_d & ~error_d;
                end
            end
        end
    end

endmodule // oag_addr_gen

`default_nettype wire

// [pkg/oag_defines.vh]
// constants for the operand address generator
`ifndef OAG_DEFINES_VH
`define OAG_DEFINES_VH

// addressing modes on req_mode
`define OAG_MODE_W        3
`define OAG_MODE_REG      3'h0
`define OAG_MODE_IND      3'h1
`define OAG_MODE_IDX      3'h2
`define OAG_MODE_ABS      3'h3
`define OAG_MODE_VEC      3'h4
`define OAG_MODE_REL      3'h5
`define OAG_MODE_LIT      3'h6

// instruction classes on req_op
`define OAG_OP_W          4
`define OAG_OP_OTHER      4'h0
`define OAG_OP_LD         4'h1
`define OAG_OP_LDC        4'h2
`define OAG_OP_LDE        4'h3
`define OAG_OP_JP         4'h4
`define OAG_OP_CALL       4'h5
`define OAG_OP_BTJF       4'h6
`define OAG_OP_BTJT       4'h7
`define OAG_OP_DECREMENT_JUMP_NONZERO_OP       4'h8
`define OAG_OP_COMPARE_INC_JUMP_EQUAL_OP      4'h9
`define OAG_OP_COMPARE_INC_JUMP_UNEQUAL_OP     4'ha
`define OAG_OP_JR         4'hb

// target spaces on res_space
`define OAG_SP_W          3
`define OAG_SP_NONE       3'h0
`define OAG_SP_RF         3'h1
`define OAG_SP_PROG       3'h2
`define OAG_SP_EXT        3'h3
`define OAG_SP_PC         3'h4
`define OAG_SP_LIT        3'h5

// working register decoding
`define OAG_WR_NIBBLE     4'hc
`define OAG_SET1_HI       2'h3
`define OAG_PTR_SEL_BIT   3
`define OAG_VEC_PAGE      8'h00

// controller states, one-hot
`define OAG_ST_W          2
`define OAG_ST_IDLE       2'h1
`define OAG_ST_VEC        2'h2

`endif

// [bench/oag_vec_mem.sv]
// partner model: low program page answering vector word reads
`default_nettype none
module oag_vec_mem (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // answer delay, 0 is prompt
    input  wire logic [3:0]  dly,
    // vector read port
    input  wire logic        vec_rd_q,
    input  wire logic [15:0] vec_addr_q,
    output var  logic        vec_valid,
    output var  logic [15:0] vec_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt_q;
    logic [15:0] word_q;
    always @(posedge core_clk) begin
        vec_valid <= 1'b0;
        // toggles outside answers so a late sample never sees the old word
        vec_data  <= ~vec_data;
        if (srst) begin
            cnt_q    <= 4'h0;
            vec_data <= 16'h0f0f;
        end else if (vec_rd_q) begin
            word_q <= {8'h12, vec_addr_q[7:0]};
            cnt_q  <= dly;
            if (dly == 4'h0) begin
                vec_valid <= 1'b1;
                vec_data  <= {8'h12, vec_addr_q[7:0]};
            end
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                vec_valid <= 1'b1;
                vec_data  <= word_q;
            end
        end
    end
endmodule // oag_vec_mem
`default_nettype wire

// [bench/oag_addr_gen_asserts.sv]
// port-level assertions for the address generator
`default_nettype none
`include "oag_defines.vh"
module oag_addr_gen_asserts (
    // clock, reset and request
    input wire logic        core_clk, srst, req_valid, imm_wide, idx_short,
    input wire logic [2:0]  req_mode,
    input wire logic [3:0]  req_op,
    input wire logic [7:0]  reg_field, reg_val,
    input wire logic [15:0] imm_val, pair_val, pc_next,
    // answer
    input wire logic        ready_q, res_error_q, pc_load_q, vec_rd_q,
    input wire logic [15:0] res_addr_q, res_operand_q, vec_addr_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire        tk = req_valid && ready_q;
    wire [15:0] sx = {{8{imm_val[7]}}, imm_val[7:0]};
    wire [7:0]  idx_sum = imm_val[7:0] + reg_val;
    wire        rel = tk && req_mode == `OAG_MODE_REL;
    wire        vec = tk && req_mode == `OAG_MODE_VEC;
    wire        idx = tk && req_mode == `OAG_MODE_IDX;
    a_rel_pc_sum: assert property (rel && req_op == `OAG_OP_JR |=>
        pc_load_q && res_addr_q == $past(pc_next) + $past(sx)) else $error("relative target wrong");
    a_rel_ops_only: assert property (rel && req_op < `OAG_OP_BTJF |=>
        res_error_q && !pc_load_q) else $error("relative taken for wrong op");
    a_abs_pc_load: assert property (tk && req_mode == `OAG_MODE_ABS && req_op == `OAG_OP_JP |=>
        pc_load_q && res_addr_q == $past(imm_val)) else $error("jump target wrong");
    a_lit_operand: assert property (tk && req_mode == `OAG_MODE_LIT |=>
        res_operand_q == ($past(imm_wide) ? $past(imm_val) : $past(imm_val) & 16'h00ff)) else $error("literal wrong");
    a_idx_file_wrap: assert property (idx && req_op == `OAG_OP_LD && !idx_short |=>
        res_addr_q == {8'h00, $past(idx_sum)}) else $error("file index sum wrong");
    a_idx_ext_sext: assert property (idx && req_op == `OAG_OP_LDE && idx_short |=>
        res_addr_q == $past(pair_val) + $past(sx)) else $error("short offset not sign extended");
    a_vec_page_rd: assert property (vec && req_op == `OAG_OP_CALL |=>
        vec_rd_q && !ready_q && vec_addr_q == {8'h00, $past(reg_field)}) else $error("vector read wrong");
    a_vec_call_only: assert property (vec && req_op != `OAG_OP_CALL |=>
        res_error_q && !vec_rd_q ##1 !vec_rd_q) else $error("vector mode taken for non-call");
    a_ready_drop: assert property ($fell(ready_q) && !$past(srst) |-> vec_rd_q)
        else $error("ready dropped outside vector wait");
    c_vec: cover property (vec && req_op == `OAG_OP_CALL);
    c_rel: cover property (rel && req_op == `OAG_OP_JR);
    c_idx_wrap: cover property (idx && imm_val[7:0] > ~reg_val);
endmodule // oag_addr_gen_asserts
bind oag_addr_gen oag_addr_gen_asserts chk_u (
    .core_clk(core_clk), .srst(srst), .req_valid(req_valid), .imm_wide(imm_wide),
    .idx_short(idx_short), .req_mode(req_mode), .req_op(req_op), .reg_field(reg_field),
    .reg_val(reg_val), .imm_val(imm_val), .pair_val(pair_val), .pc_next(pc_next),
    .ready_q(ready_q), .res_error_q(res_error_q), .pc_load_q(pc_load_q), .vec_rd_q(vec_rd_q),
    .res_addr_q(res_addr_q), .res_operand_q(res_operand_q), .vec_addr_q(vec_addr_q)
);
`default_nettype wire

// [bench/tb_operand_address_generator.sv]
// self-checking bench for the operand address generator
`default_nettype none
`include "oag_defines.vh"
module tb_operand_address_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, srst = 1'b1, req_valid = 1'b0, reg_short = 1'b0;
    logic        reg_wide = 1'b0, imm_wide = 1'b0, idx_short = 1'b0;
    logic [2:0]  req_mode = 3'h0;
    logic [3:0]  req_op = 4'h0, dly = 4'h0;
    logic [7:0]  reg_field = 8'h00, wp0 = 8'h00, wp1 = 8'h00, reg_val = 8'h00;
    logic [15:0] imm_val = 16'h0000, pair_val = 16'h0000, pc_next = 16'h0000;
    wire logic   vec_valid, ready_q, res_valid_q, res_alt_set_q, res_error_q, pc_load_q, vec_rd_q;
    wire logic [2:0]  res_space_q;
    wire logic [7:0]  res_reg_q;
    wire logic [15:0] vec_data, res_addr_q, res_operand_q, vec_addr_q;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    oag_addr_gen dut_u (
        .core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req_mode(req_mode),
        .req_op(req_op), .reg_field(reg_field), .reg_short(reg_short), .reg_wide(reg_wide),
        .imm_val(imm_val), .imm_wide(imm_wide), .idx_short(idx_short),
        .first_window_pointer(wp0), .second_window_pointer(wp1), .reg_val(reg_val),
        .pair_val(pair_val), .pc_next(pc_next), .vec_valid(vec_valid), .vec_data(vec_data),
        .ready_q(ready_q), .res_valid_q(res_valid_q), .res_space_q(res_space_q),
        .res_addr_q(res_addr_q), .res_operand_q(res_operand_q), .res_reg_q(res_reg_q),
        .res_alt_set_q(res_alt_set_q), .res_error_q(res_error_q), .pc_load_q(pc_load_q),
        .vec_rd_q(vec_rd_q), .vec_addr_q(vec_addr_q)
    );
    oag_vec_mem mem_u (
        .core_clk(core_clk), .srst(srst), .dly(dly), .vec_rd_q(vec_rd_q),
        .vec_addr_q(vec_addr_q), .vec_valid(vec_valid), .vec_data(vec_data)
    );
    task automatic close_out;
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // valid stays high so consecutive calls are back to back; space 0 skips space and address
    task automatic step(logic [3:0] op, logic [15:0] imm, logic [2:0] sp, logic [15:0] ad, logic er, logic pl);
        req_op = op;
        imm_val = imm;
        req_valid = 1'b1;
        @(negedge core_clk);
        chk("flags", 16'({res_valid_q, res_error_q, pc_load_q}), 16'({1'b1, er, pl}));
        if (!er && sp != 3'h0) begin
            chk("space", 16'(res_space_q), 16'(sp));
            chk("addr", res_addr_q, ad);
        end
    endtask
    task automatic t_reg;
        req_mode = `OAG_MODE_REG;
        reg_val = 8'h5a;
        reg_short = 1'b1;
        reg_field = 8'h0e;
        wp1 = 8'ha8;
        step(`OAG_OP_LD, 16'h0, 3'h0, 16'h0, 1'b0, 1'b0);
        chk("operand", res_operand_q, 16'h005a);
        chk("wreg", 16'(res_reg_q), 16'h00ae);
        reg_short = 1'b0;
        reg_wide = 1'b1;
        reg_field = 8'hcb;
        pair_val = 16'h1234;
        step(`OAG_OP_LD, 16'h0, 3'h0, 16'h0, 1'b0, 1'b0);
        chk("operand", res_operand_q, 16'h1234);
        chk("wreg", 16'(res_reg_q), 16'h00ab);
        reg_field = 8'hc3;
        wp0 = 8'h70;
        step(`OAG_OP_LD, 16'h0, 3'h0, 16'h0, 1'b0, 1'b0);
        chk("wreg", 16'(res_reg_q), 16'h0073);
        reg_field = 8'h45;
        step(`OAG_OP_LD, 16'h0, 3'h0, 16'h0, 1'b0, 1'b0);
        chk("wreg", 16'(res_reg_q), 16'h0045);
    endtask
    task automatic t_ind_idx;
        req_mode = `OAG_MODE_IND;
        reg_wide = 1'b0;
        reg_val = 8'hc5;
        step(`OAG_OP_LD, 16'h0, `OAG_SP_RF, 16'h00c5, 1'b0, 1'b0);
        chk("alt_set", 16'(res_alt_set_q), 16'h1);
        reg_val = 8'hbf;
        step(`OAG_OP_LD, 16'h0, `OAG_SP_RF, 16'h00bf, 1'b0, 1'b0);
        chk("alt_set", 16'(res_alt_set_q), 16'h0);
        reg_wide = 1'b1;
        pair_val = 16'h8001;
        step(`OAG_OP_LDC, 16'h0, `OAG_SP_PROG, 16'h8001, 1'b0, 1'b0);
        step(`OAG_OP_LDE, 16'h0, `OAG_SP_EXT, 16'h8001, 1'b0, 1'b0);
        reg_wide = 1'b0;
        req_mode = `OAG_MODE_IDX;
        reg_val = 8'h90;
        step(`OAG_OP_LD, 16'h0080, `OAG_SP_RF, 16'h0010, 1'b0, 1'b0);
        reg_val = 8'h95;
        step(`OAG_OP_LD, 16'h0030, `OAG_SP_RF, 16'h00c5, 1'b0, 1'b0);
        chk("alt_set", 16'(res_alt_set_q), 16'h1);
        pair_val = 16'h1000;
        step(`OAG_OP_LDE, 16'h0200, `OAG_SP_EXT, 16'h1200, 1'b0, 1'b0);
        step(`OAG_OP_LDC, 16'h0200, `OAG_SP_PROG, 16'h1200, 1'b0, 1'b0);
        step(`OAG_OP_JP, 16'h0200, 3'h0, 16'h0, 1'b1, 1'b0);
        idx_short = 1'b1;
        step(`OAG_OP_LDE, 16'h00f0, `OAG_SP_EXT, 16'h0ff0, 1'b0, 1'b0);
        step(`OAG_OP_LDE, 16'h007f, `OAG_SP_EXT, 16'h107f, 1'b0, 1'b0);
        step(`OAG_OP_LD, 16'h00f0, 3'h0, 16'h0, 1'b1, 1'b0);
        idx_short = 1'b0;
    endtask
    task automatic t_jump_lit;
        req_mode = `OAG_MODE_ABS;
        step(`OAG_OP_JP, 16'hbeef, `OAG_SP_PC, 16'hbeef, 1'b0, 1'b1);
        step(`OAG_OP_CALL, 16'h0123, `OAG_SP_PC, 16'h0123, 1'b0, 1'b1);
        step(`OAG_OP_LDC, 16'h4000, `OAG_SP_PROG, 16'h4000, 1'b0, 1'b0);
        step(`OAG_OP_LDE, 16'h8000, `OAG_SP_EXT, 16'h8000, 1'b0, 1'b0);
        req_mode = `OAG_MODE_REL;
        pc_next = 16'h0100;
        for (int op = 6; op < 12; op++) begin
            step(4'(op), 16'h00fe, `OAG_SP_PC, 16'h00fe, 1'b0, 1'b1);
        end
        step(`OAG_OP_JR, 16'h007f, `OAG_SP_PC, 16'h017f, 1'b0, 1'b1);
        step(`OAG_OP_JR, 16'h0080, `OAG_SP_PC, 16'h0080, 1'b0, 1'b1);
        step(`OAG_OP_LD, 16'h00fe, 3'h0, 16'h0, 1'b1, 1'b0);
        req_mode = 3'h7;
        step(`OAG_OP_LD, 16'h00fe, 3'h0, 16'h0, 1'b1, 1'b0);
        req_mode = `OAG_MODE_LIT;
        step(`OAG_OP_LD, 16'h12ab, `OAG_SP_LIT, 16'h0, 1'b0, 1'b0);
        chk("operand", res_operand_q, 16'h00ab);
        imm_wide = 1'b1;
        step(`OAG_OP_LD, 16'h12ab, `OAG_SP_LIT, 16'h0, 1'b0, 1'b0);
        chk("operand", res_operand_q, 16'h12ab);
    endtask
    task automatic t_vec;
        req_mode = `OAG_MODE_VEC;
        reg_field = 8'h40;
        req_op = `OAG_OP_CALL;
        for (int d = 0; d < 6; d += 5) begin
            dly = 4'(d);
            req_valid = 1'b1;
            @(negedge core_clk);
            req_valid = 1'b0;
            chk("vec_rd", 16'({vec_rd_q, ready_q}), 16'h2);
            chk("vec_addr", vec_addr_q, 16'h0040);
            for (int i = 0; i < 12 && res_valid_q !== 1'b1; i++) begin
                @(negedge core_clk);
            end
            chk("vec_target", res_addr_q, 16'h1240);
            chk("vec_flags", 16'({res_valid_q, pc_load_q, ready_q}), 16'h7);
        end
        step(`OAG_OP_JP, 16'h0, 3'h0, 16'h0, 1'b1, 1'b0);
        req_valid = 1'b0;
    endtask
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        @(negedge core_clk);
        chk("ready", 16'(ready_q), 16'h1);
        t_reg();
        t_ind_idx();
        t_jump_lit();
        t_vec();
        close_out();
    end
endmodule // tb_operand_address_generator
`default_nettype wire
